/* File: shared/app_params.svh */
// offsets, field positions, reset values and timing counts of the parallel port
// assumes: included by package and design files by bare name
`ifndef APP_PARAMS_SVH
`define APP_PARAMS_SVH

// ==========================================================
// register offsets
`define APP_AW           4
`define APP_DW           8
`define APP_OFF_CFG      4'h0
`define APP_OFF_PORT0    4'h1
`define APP_OFF_PORT1    4'h2
`define APP_OFF_PORT2    4'h3
`define APP_OFF_IRQ_STS  4'h4
`define APP_OFF_IRQ_MSK  4'h5

// ==========================================================
// configuration fields
`define APP_CFG_WID_LO   0
`define APP_CFG_WID_HI   1
`define APP_CFG_RDY      2
`define APP_CFG_FREE     3
`define APP_CFG_RDY_POL  4
`define APP_CFG_FREE_POL 5
`define APP_CFG_EN       6
`define APP_CFG_RST      8'h00

// ==========================================================
// interrupt fields
`define APP_IRQ_RD_DONE  0
`define APP_IRQ_WR_DONE  1
`define APP_IRQ_RST      2'h0

// ==========================================================
// timing
`define APP_SYNC_STAGES  2
`define APP_PIN_W        24

`endif

/* File: shared/app_pkg.sv */
// types shared by the parallel port modules
// assumes: app_params.svh is on the include path
`include "app_params.svh"

package app_pkg;
   // ==========================================================
   // transfer width selection
   typedef enum logic [1:0] {
      APP_W8  = 2'h0,
      APP_W16 = 2'h1,
      APP_W24 = 2'h3,
      APP_WX  = 2'h2
   } app_width_t;

   typedef logic [`APP_AW-1:0] app_addr_t;
   typedef logic [`APP_DW-1:0] app_data_t;
endpackage : app_pkg

/* File: shared/app_sync_if.sv */
// carries a group of asynchronous pin levels and their synchronised copies
// assumes: one clock domain on both sides
`timescale 1ns/1ps

interface app_sync_if #(parameter int W = 1);
   logic [W-1:0] async_v;
   logic [W-1:0] sync_v;

   modport sync (input async_v, output sync_v);
   modport user (output async_v, input sync_v);
endinterface : app_sync_if

/* File: design/app_sync.sv */
// two flip-flop synchroniser for a group of pin levels
// assumes: async_v comes from outside the clk_i domain
`timescale 1ns/1ps

module app_sync #(
   parameter int W = 1
) (
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   app_sync_if.sync   pins
);
   import app_pkg::*;

   logic [W-1:0] meta_q;
   logic [W-1:0] stable_q;

   // first stage is read only by the second stage
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q   <= '1;
         stable_q <= '1;
      end else begin
         meta_q   <= pins.async_v;
         stable_q <= meta_q;
      end
   end

   assign pins.sync_v = stable_q;
endmodule : app_sync

/* File: design/app_port.sv */
// assisted parallel port: 8/16/24-bit word exchange with an external host
// assumes: host pins are asynchronous; firmware uses the plain register port
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "app_params.svh"

module app_port (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // register port
   input  wire app_pkg::app_addr_t        reg_addr_i,
   input  wire app_pkg::app_data_t        reg_wdata_i,
   input  wire logic                      reg_wr_i,
   input  wire logic                      reg_rd_i,
   output      app_pkg::app_data_t        reg_rdata_o,
   output      logic                      irq_o,
   // host pins
   input  wire logic                      host_write_strobe_n_i,
   input  wire logic                      host_oe_n_i,
   input  wire logic                      host_cs_n_i,
   input  wire logic [`APP_PIN_W-1:0]     pd_i,
   output      logic [`APP_PIN_W-1:0]     pd_o,
   output      logic [`APP_PIN_W-1:0]     pd_oe_o,
   output      logic                      output_valid_out_o,
   output      logic                      input_free_out_o,
   output      logic                      handshake_oe_o
);
   import app_pkg::*;

   // ==========================================================
   // pin synchronisers
   app_sync_if #(.W(3))          ctl_if ();
   app_sync_if #(.W(`APP_PIN_W)) dat_if ();

   assign ctl_if.async_v = {host_cs_n_i, host_oe_n_i, host_write_strobe_n_i};
   assign dat_if.async_v = pd_i;

   app_sync #(.W(3)) u_ctl_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pins  (ctl_if)
   );

   app_sync #(.W(`APP_PIN_W)) u_dat_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pins  (dat_if)
   );

   // ==========================================================
   // registers
   app_data_t               cfg_q;
   logic [`APP_PIN_W-1:0]   out_latch_q;
   logic [`APP_PIN_W-1:0]   in_latch_q;
   logic                    rdy_q;
   logic                    free_q;
   logic                    rd_act_q;
   logic                    wr_act_q;
   logic [1:0]              sts_q;
   logic [1:0]              sts_d;
   logic [1:0]              msk_q;
   logic [`APP_PIN_W-1:0]   drive_q;
   app_data_t               rdata_q;

   // ==========================================================
   // decode
   wire        en        = cfg_q[`APP_CFG_EN];
   wire        pol_rdy   = cfg_q[`APP_CFG_RDY_POL];
   wire        pol_free  = cfg_q[`APP_CFG_FREE_POL];
   wire        strobe_s  = ctl_if.sync_v[0];
   wire        oe_s      = ctl_if.sync_v[1];
   wire        cs_s      = ctl_if.sync_v[2];
   wire        host_rd   = en & ~cs_s & ~oe_s;
   wire        host_wr   = en & ~cs_s & ~strobe_s;
   wire        rd_done   = rd_act_q & ~host_rd;
   wire        wr_done   = wr_act_q & ~host_wr;
   wire        wr_cfg;
   wire        wr_p0;
   wire        wr_p1;
   wire        wr_p2;
   wire        wr_sts;
   wire        wr_msk;
   wire        rd_p0     = reg_rd_i & (reg_addr_i == `APP_OFF_PORT0);

   assign wr_cfg = reg_wr_i & (reg_addr_i == `APP_OFF_CFG);
   assign wr_p0  = reg_wr_i & (reg_addr_i == `APP_OFF_PORT0);
   assign wr_p1  = reg_wr_i & (reg_addr_i == `APP_OFF_PORT1);
   assign wr_p2  = reg_wr_i & (reg_addr_i == `APP_OFF_PORT2);
   assign wr_sts = reg_wr_i & (reg_addr_i == `APP_OFF_IRQ_STS);
   assign wr_msk = reg_wr_i & (reg_addr_i == `APP_OFF_IRQ_MSK);

   // width selection: lanes driven during a host read
   app_width_t              width;
   logic [`APP_PIN_W-1:0]   lane_mask;
   assign width     = app_width_t'(cfg_q[`APP_CFG_WID_HI:`APP_CFG_WID_LO]);
   assign lane_mask = (width == APP_W8)  ? 24'h0000ff :
                      (width == APP_W16) ? 24'h00ffff : 24'hffffff;

   // status bits read opposite to the pins while the port is enabled
   wire rdy_pin  = rdy_q ^ pol_rdy;
   wire free_pin = free_q ^ pol_free;

   // ==========================================================
   // configuration and output latches
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_q <= `APP_CFG_RST;
      end else if (wr_cfg) begin
         cfg_q <= reg_wdata_i & 8'h73;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_latch_q <= '0;
      end else begin
         if (wr_p0) out_latch_q[7:0]   <= reg_wdata_i;
         if (wr_p1) out_latch_q[15:8]  <= reg_wdata_i;
         if (wr_p2) out_latch_q[23:16] <= reg_wdata_i;
      end
   end

   // ==========================================================
   // handshake state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdy_q <= 1'b0;
      end else if (wr_p0 & en) begin
         rdy_q <= 1'b1;
      end else if (host_rd) begin
         rdy_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         free_q <= 1'b1;
      end else if (rd_p0 & en) begin
         free_q <= 1'b1;
      end else if (host_wr) begin
         free_q <= 1'b0;
      end
   end

   // capture tracks the bus while strobe is low; last value stands
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         in_latch_q <= '0;
      end else if (host_wr) begin
         in_latch_q <= dat_if.sync_v & lane_mask;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
         drive_q  <= '0;
      end else begin
         rd_act_q <= host_rd;
         wr_act_q <= host_wr;
         drive_q  <= host_rd ? lane_mask : '0;
      end
   end

   // ==========================================================
   // interrupts: sticky, write one to clear, set wins
   assign sts_d = (sts_q & ~(wr_sts ? reg_wdata_i[1:0] : 2'h0)) | {wr_done, rd_done};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sts_q <= `APP_IRQ_RST;
         msk_q <= `APP_IRQ_RST;
      end else begin
         sts_q <= sts_d;
         if (wr_msk) msk_q <= reg_wdata_i[1:0];
      end
   end

   assign irq_o = |(sts_q & msk_q);

   // ==========================================================
   // register read
   app_data_t rd_mux;
   assign rd_mux =
      (reg_addr_i == `APP_OFF_CFG)     ? {cfg_q[7:4], ~free_pin, ~rdy_pin, cfg_q[1:0]} :
      (reg_addr_i == `APP_OFF_PORT0)   ? in_latch_q[7:0] :
      (reg_addr_i == `APP_OFF_PORT1)   ? in_latch_q[15:8] :
      (reg_addr_i == `APP_OFF_PORT2)   ? in_latch_q[23:16] :
      (reg_addr_i == `APP_OFF_IRQ_STS) ? {6'h00, sts_q} :
      (reg_addr_i == `APP_OFF_IRQ_MSK) ? {6'h00, msk_q} : 8'h00;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= '0;
      end else if (reg_rd_i) begin
         rdata_q <= rd_mux;
      end
   end

   assign reg_rdata_o = rdata_q;

   // ==========================================================
   // pins
   assign pd_o               = out_latch_q;
   assign pd_oe_o            = drive_q;
   assign output_valid_out_o = en & rdy_pin;
   assign input_free_out_o   = en & free_pin;
   assign handshake_oe_o     = en;

   // ==========================================================
   // assertions
   a_ready_set_on_p0: assert property (
      @(posedge clk_i) disable iff (rst_i) (wr_p0 && en) |=> rdy_q)
      else $error("port 0 write did not set data ready");

   a_ready_clr_on_oe: assert property (
      @(posedge clk_i) disable iff (rst_i) (host_rd && !wr_p0) |=> !rdy_q)
      else $error("host read did not clear data ready");

   a_free_set_on_p0: assert property (
      @(posedge clk_i) disable iff (rst_i) (rd_p0 && en) |=> free_q)
      else $error("port 0 read did not set latch empty");

   a_free_clr_on_stb: assert property (
      @(posedge clk_i) disable iff (rst_i) (host_wr && !rd_p0) |=> !free_q)
      else $error("host write did not clear latch empty");

   a_cs_gates_both: assert property (
      @(posedge clk_i) disable iff (rst_i) cs_s |=> !rd_act_q && !wr_act_q)
      else $error("strobe or output enable acted without chip select");

   a_rdy_bit_vs_pin: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (reg_rd_i && reg_addr_i == `APP_OFF_CFG && en && !host_rd && !reg_wr_i)
      |=> reg_rdata_o[`APP_CFG_RDY] != output_valid_out_o)
      else $error("data ready bit equals its pin");

   a_free_bit_vs_pin: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (reg_rd_i && reg_addr_i == `APP_OFF_CFG && en && !host_wr && !reg_wr_i)
      |=> reg_rdata_o[`APP_CFG_FREE] != input_free_out_o)
      else $error("latch empty bit equals its pin");

   a_drive_only_read: assert property (
      @(posedge clk_i) disable iff (rst_i) (pd_oe_o != '0) |-> $past(host_rd))
      else $error("data pins driven outside a host read");

   a_drive_during_rd: assert property (
      @(posedge clk_i) disable iff (rst_i) host_rd |=> pd_oe_o[7:0] == 8'hff)
      else $error("data pins not driven during host read");

   a_rd_done_irq: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rd_done && msk_q[`APP_IRQ_RD_DONE]) |=> sts_q[`APP_IRQ_RD_DONE] && irq_o)
      else $error("read end did not raise the interrupt");

   a_wr_done_irq: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (wr_done && msk_q[`APP_IRQ_WR_DONE]) |=> sts_q[`APP_IRQ_WR_DONE] && irq_o)
      else $error("write end did not raise the interrupt");

   // ==========================================================
   // assertions: holding, release and lanes
   a_ready_holds: assert property (
      @(posedge clk_i) disable iff (rst_i) (rdy_q && !host_rd) |=> rdy_q)
      else $error("data ready dropped without a host read");

   a_free_holds: assert property (
      @(posedge clk_i) disable iff (rst_i) (free_q && !host_wr) |=> free_q)
      else $error("latch empty dropped without a host write");

   a_full_holds: assert property (
      @(posedge clk_i) disable iff (rst_i) (!free_q && !(rd_p0 && en)) |=> !free_q)
      else $error("latch empty rose without a port 0 read");

   a_rd_sts_sticky: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (sts_q[`APP_IRQ_RD_DONE] && !(wr_sts && reg_wdata_i[`APP_IRQ_RD_DONE]))
      |=> sts_q[`APP_IRQ_RD_DONE])
      else $error("read done status dropped without a clear");

   a_wr_sts_sticky: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (sts_q[`APP_IRQ_WR_DONE] && !(wr_sts && reg_wdata_i[`APP_IRQ_WR_DONE]))
      |=> sts_q[`APP_IRQ_WR_DONE])
      else $error("write done status dropped without a clear");

   a_sts_w1c: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (wr_sts && reg_wdata_i[`APP_IRQ_RD_DONE] && !rd_done) |=> !sts_q[`APP_IRQ_RD_DONE])
      else $error("read done status not cleared by a one");

   a_disabled_quiet: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !en |-> !output_valid_out_o && !input_free_out_o && !handshake_oe_o)
      else $error("handshake pins active while the port is off");

   a_release_idle: assert property (
      @(posedge clk_i) disable iff (rst_i) !host_rd |=> pd_oe_o == '0)
      else $error("data pins still driven after the host read");

   a_drive_lanes: assert property (
      @(posedge clk_i) disable iff (rst_i) (host_rd && !wr_cfg) |=> pd_oe_o == lane_mask)
      else $error("driven lanes do not match the width");

   a_capture_lanes: assert property (
      @(posedge clk_i) disable iff (rst_i) (host_wr && !wr_cfg) |=> (in_latch_q & ~lane_mask) == '0)
      else $error("unused lanes captured");

   a_capture_data: assert property (
      @(posedge clk_i) disable iff (rst_i)
      host_wr |=> in_latch_q == ($past(dat_if.sync_v) & $past(lane_mask)))
      else $error("host write data not captured");

   a_p0_to_pins: assert property (
      @(posedge clk_i) disable iff (rst_i) wr_p0 |=> pd_o[7:0] == $past(reg_wdata_i))
      else $error("port 0 write did not reach the output latch");

   a_cfg_ro_bits: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_cfg |=> cfg_q[7] == 1'h0 && cfg_q[`APP_CFG_FREE:`APP_CFG_RDY] == 2'h0)
      else $error("read-only configuration bits were written");

   a_wr_done_pulse: assert property (
      @(posedge clk_i) disable iff (rst_i) wr_done |=> !wr_done)
      else $error("write end lasted more than one cycle");

   // ==========================================================
   // main scenarios
   c_inv_polarity: cover property (@(posedge clk_i) disable iff (rst_i)
                                   host_wr && pol_free && pol_rdy);
   c_masked_done:  cover property (@(posedge clk_i) disable iff (rst_i)
                                   rd_done && !msk_q[`APP_IRQ_RD_DONE]);
   c_host_read:  cover property (@(posedge clk_i) disable iff (rst_i) rdy_q ##[1:20] rd_done);
   c_host_write: cover property (@(posedge clk_i) disable iff (rst_i) free_q ##[1:20] wr_done);
   c_wide_read:  cover property (@(posedge clk_i) disable iff (rst_i)
                                 host_rd && width == APP_W24);
endmodule : app_port

/* File: verif/app_host_model.sv */
// external host model for the parallel port pins
// assumes: shares the device clock; pins change right after rising edges
`timescale 1ns/1ps

module app_host_model (
   input  wire logic        clk_i,
   input  wire logic [23:0] pd_o_i,
   input  wire logic [23:0] pd_oe_i,
   output      logic        host_write_strobe_n_o,
   output      logic        host_oe_n_o,
   output      logic        host_cs_n_o,
   output      logic [23:0] pd_bus_o
);
   logic [23:0] wr_q;
   logic [23:0] tog_q;
   logic        drv_en_q;

   initial begin
      host_write_strobe_n_o = 1'b1;
      host_oe_n_o = 1'b1;
      host_cs_n_o = 1'b1;
      drv_en_q = 1'b0;
      wr_q = 24'h000000;
      tog_q = 24'h5a5a5a;
   end

   // undriven lines flip every cycle so stale data never looks valid
   always @(posedge clk_i) tog_q <= ~tog_q;
   assign pd_bus_o = (pd_oe_i & pd_o_i) | (~pd_oe_i & (drv_en_q ? wr_q : tog_q));

   // ==========================================================
   // host read, optionally without chip select
   task automatic read_word(input logic use_cs, output logic [23:0] d,
                            output logic [23:0] en);
      @(posedge clk_i);
      host_oe_n_o <= 1'b0;
      host_cs_n_o <= !use_cs;
      repeat (5) @(posedge clk_i);
      #1;
      d = pd_bus_o;
      en = pd_oe_i;
      @(posedge clk_i);
      host_oe_n_o <= 1'b1;
      host_cs_n_o <= 1'b1;
      repeat (6) @(posedge clk_i);
   endtask : read_word

   // ==========================================================
   // host write, data held through the strobe rise
   task automatic write_word(input logic [23:0] d);
      @(posedge clk_i);
      wr_q <= d;
      drv_en_q <= 1'b1;
      host_cs_n_o <= 1'b0;
      host_write_strobe_n_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      host_write_strobe_n_o <= 1'b1;
      host_cs_n_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      drv_en_q <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : write_word
endmodule : app_host_model

/* File: verif/app_port_test.sv */
// self-checking bench for the parallel port with a host model on its pins
// assumes: app_params.svh on the include path, app_pkg compiled first
`timescale 1ns/1ps
`include "app_params.svh"

module app_port_test;
   import app_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   app_addr_t reg_addr_i = '0;
   app_data_t reg_wdata_i = '0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   app_data_t reg_rdata_o;
   logic irq_o, stb_n, oe_n, cs_n, ov, fr, hs_oe;
   logic [23:0] pd_i, pd_o, pd_oe_o, p, q, d, en;
   app_data_t r;
   logic [1:0] w, msk;
   logic pr, pf;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [1:0] w_tab [4] = '{2'h0, 2'h1, 2'h3, 2'h2};

   always #5 clk_i = ~clk_i;

   app_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .host_write_strobe_n_i(stb_n),
      .host_oe_n_i(oe_n), .host_cs_n_i(cs_n), .pd_i(pd_i), .pd_o(pd_o),
      .pd_oe_o(pd_oe_o), .output_valid_out_o(ov), .input_free_out_o(fr),
      .handshake_oe_o(hs_oe));

   app_host_model i_host (.clk_i(clk_i), .pd_o_i(pd_o), .pd_oe_i(pd_oe_o),
      .host_write_strobe_n_o(stb_n), .host_oe_n_o(oe_n), .host_cs_n_o(cs_n),
      .pd_bus_o(pd_i));

   // ==========================================================
   // helpers
   function automatic logic [23:0] lane_mask(input logic [1:0] wid);
      case (wid)
         2'h0: return 24'h0000ff;
         2'h1: return 24'h00ffff;
         default: return 24'hffffff;
      endcase
   endfunction : lane_mask

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_write(input app_addr_t a, input app_data_t v);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input app_addr_t a, output app_data_t v);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      v = reg_rdata_o;
   endtask : reg_read

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(34));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      check({irq_o, hs_oe, ov, fr}, 4'h0);
      check(pd_oe_o, 24'h0);
      reg_read(`APP_OFF_CFG, r);
      check(r, 8'h04);
      i_host.read_word(1'b1, d, en);
      check(en, 24'h0);
      for (int k = 0; k < 4; k++) begin
         w = w_tab[k];
         pr = $urandom % 2;
         pf = $urandom % 2;
         msk = $urandom % 4;
         reg_write(`APP_OFF_CFG, {2'b01, pf, pr, 2'b11, w});
         reg_write(`APP_OFF_IRQ_MSK, {6'h0, msk});
         check(hs_oe, 1'b1);
         p = $urandom;
         reg_write(`APP_OFF_PORT2, p[23:16]);
         reg_write(`APP_OFF_PORT1, p[15:8]);
         reg_write(`APP_OFF_PORT0, p[7:0]);
         reg_read(`APP_OFF_CFG, r);
         check(ov, 1'b1 ^ pr);
         check(r, {2'b01, pf, pr, pf, pr, w});
         i_host.read_word(1'b0, d, en);
         check(en, 24'h0);
         check(ov, 1'b1 ^ pr);
         i_host.read_word(1'b1, d, en);
         check(en, lane_mask(w));
         check(d & lane_mask(w), p & lane_mask(w));
         check(pd_oe_o, 24'h0);
         check(ov, pr);
         check(irq_o, msk[0]);
         reg_read(`APP_OFF_IRQ_STS, r);
         check(r, 8'h01);
         reg_write(`APP_OFF_IRQ_STS, 8'h01);
         q = $urandom;
         i_host.write_word(q);
         check(fr, pf);
         check(irq_o, msk[1]);
         reg_read(`APP_OFF_IRQ_STS, r);
         check(r, 8'h02);
         reg_write(`APP_OFF_IRQ_STS, 8'h02);
         q = q & lane_mask(w);
         reg_read(`APP_OFF_PORT2, r);
         check(r, q[23:16]);
         reg_read(`APP_OFF_PORT1, r);
         check(r, q[15:8]);
         check(fr, pf);
         reg_read(`APP_OFF_PORT0, r);
         check(r, q[7:0]);
         check(fr, 1'b1 ^ pf);
         check(irq_o, 1'b0);
      end
      reg_write(4'hf, 8'hff);
      reg_read(4'hf, r);
      check(r, 8'h00);
      reg_write(`APP_OFF_CFG, 8'h00);
      reg_read(`APP_OFF_CFG, r);
      check(r, 8'h04);
      check({hs_oe, ov, fr}, 3'h0);
      tally_and_finish();
   end
endmodule : app_port_test
